// [rtl/byte_fifo2.sv]
// Two-entry buffer with valid/ready on both sides
module byte_fifo2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [W-1:0] mem_ff [0:1];
    logic [W-1:0] nxt_mem [0:1];
    logic         wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [1:0]   fill_ff, nxt_fill;
    logic         push, pop;

    assign in_ready  = (fill_ff != 2'h2);
    assign out_valid = (fill_ff != 2'h0);
    assign out_data  = mem_ff[rd_ff];

    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        nxt_mem  = mem_ff;
        nxt_wr   = wr_ff;
        nxt_rd   = rd_ff;
        nxt_fill = fill_ff;
        if (push) begin
            nxt_mem[wr_ff] = in_data;
            nxt_wr         = ~wr_ff;
        end
        if (pop) begin
            nxt_rd = ~rd_ff;
        end
        if (push && !pop) begin
            nxt_fill = fill_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_fill = fill_ff - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            wr_ff     <= 1'b0;
            rd_ff     <= 1'b0;
            fill_ff   <= 2'h0;
        end else begin
            mem_ff  <= nxt_mem;
            wr_ff   <= nxt_wr;
            rd_ff   <= nxt_rd;
            fill_ff <= nxt_fill;
        end
    end
endmodule

// [rtl/seq_pkg.sv]
// Shared constants for the serial command sequencer
package seq_pkg;
    localparam int          BYTE_W         = 8;
    localparam int          CNT_W          = 16;
    localparam int          RESULT_W       = 24;
    localparam int          REG_COUNT      = 5;
    localparam logic [7:0]  SYNC_BYTE      = 8'h55;
    localparam logic [7:0]  CMD_RESET      = 8'h06;
    localparam logic [7:0]  CMD_START      = 8'h08;
    localparam logic [7:0]  CMD_SLEEP      = 8'h02;
    localparam logic [7:0]  CMD_READ_DATA  = 8'h10;
    localparam logic [3:0]  REG_WRITE_HI   = 4'h4;
    localparam logic [3:0]  REG_READ_HI    = 4'h2;
    localparam int          ADDR_LSB       = 1;
    localparam int          ADDR_MSB       = 3;
    localparam logic [2:0]  RESULT_BYTES   = 3'h3;
    // Falling edges of the sync byte span eight bit times between first and fifth
    localparam logic [2:0]  SYNC_EDGES     = 3'h5;
    localparam int          SYNC_SHIFT     = 3;
    localparam logic [15:0] MIN_PERIOD     = 16'h0004;
    localparam logic [15:0] RESET_PERIOD   = 16'h0010;
    localparam logic [3:0]  FRAME_BITS     = 4'h9;
    localparam int          POWER_UP_US    = 50;
    localparam int          CLK_MHZ        = 10;
    localparam int          POWER_UP_CYC   = POWER_UP_US * CLK_MHZ;
    // Register 0: input select, gain code, amplifier bypass
    localparam int          REG_INPUT      = 0;
    localparam int          SEL_MSB        = 7;
    localparam int          SEL_LSB        = 4;
    localparam int          GAIN_MSB       = 3;
    localparam int          GAIN_LSB       = 1;
    localparam int          BYPASS_BIT     = 0;
    localparam logic [3:0]  SEL_MID_SHORT  = 4'hE;
    localparam logic [2:0]  GAIN_MAX_BYP   = 3'h2;
    // Register 1: conversion mode
    localparam int          REG_MODE       = 1;
    localparam int          CONT_BIT       = 3;
    // Register 4: pin directions, ready select, pin levels
    localparam int          REG_PINS       = 4;
    localparam int          DIR_LSB        = 4;
    localparam int          READY_SEL_BIT  = 3;
    localparam logic [7:0]  REG_RESET      = 8'h00;
endpackage

// [rtl/uart_adc_command_sequencer.sv]
// Serial command layer of the measurement converter
module uart_adc_command_sequencer (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        RESET_N_PIN,
    input  wire logic        RX,
    output logic             TX,
    input  wire logic        CONV_DONE,
    input  wire logic [23:0] CONV_DATA,
    output logic             CONV_RUN,
    output logic             LOW_POWER,
    output logic      [3:0]  INPUT_SELECT,
    output logic      [2:0]  GAIN_CODE,
    output logic             AMP_BYPASS,
    output logic             MID_SHORT,
    input  wire logic        GENERAL_PIN_0_IN,
    output logic             GENERAL_PIN_0_OUT,
    output logic             GENERAL_PIN_0_OE_N,
    input  wire logic        GENERAL_PIN_1_IN,
    output logic             GENERAL_PIN_1_OUT,
    output logic             GENERAL_PIN_1_OE_N,
    input  wire logic        SHARED_IO_READY_PIN_IN,
    output logic             SHARED_IO_READY_PIN_OUT,
    output logic             SHARED_IO_READY_PIN_OE_N
);
    typedef enum logic [4:0] {
        X_IDLE = 5'h01, X_START = 5'h02, X_DATA = 5'h04, X_STOP = 5'h08, X_END = 5'h10
    } rx_state_t;
    typedef enum logic [2:0] {
        P_SYNC = 3'h1, P_CMD = 3'h2, P_WDATA = 3'h4
    } proto_state_t;
    typedef enum logic [1:0] {
        T_IDLE = 2'h1, T_SHIFT = 2'h2
    } tx_state_t;

    // Pin synchronisers: bit 0 rx, 1 reset, 2..4 general pins
    logic [4:0]  sync_a_ff, sync_b_ff;
    logic        rx_s, reset_n_s, core_rst;
    logic [2:0]  pin_s;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sync_a_ff <= 5'h1F;
            sync_b_ff <= 5'h1F;
        end else begin
            sync_a_ff <= {SHARED_IO_READY_PIN_IN, GENERAL_PIN_1_IN, GENERAL_PIN_0_IN,
                          RESET_N_PIN, RX};
            sync_b_ff <= sync_a_ff;
        end
    end

    assign rx_s      = sync_b_ff[0];
    assign reset_n_s = sync_b_ff[1];
    assign pin_s     = sync_b_ff[4:2];

    // Soft reset covers the pin and the reset command alike
    logic soft_rst_ff, nxt_soft_rst;
    assign core_rst = RST || !reset_n_s || soft_rst_ff;

    // Receive framing and baud measurement
    rx_state_t    xstate_ff, nxt_xstate;
    proto_state_t pstate_ff, nxt_pstate;
    logic [15:0]  cnt_ff, nxt_cnt, period_ff, nxt_period;
    logic [2:0]   edges_ff, nxt_edges, bitn_ff, nxt_bitn;
    logic [7:0]   shift_ff, nxt_shift, byte_ff, nxt_byte;
    logic         rx_prev_ff, byte_pls_ff, nxt_byte_pls, sync_pls_ff, nxt_sync_pls;
    logic         fall, hunting;

    always_comb begin
        fall         = rx_prev_ff && !rx_s;
        hunting      = (pstate_ff == P_SYNC);
        nxt_xstate   = xstate_ff;
        nxt_cnt      = cnt_ff;
        nxt_period   = period_ff;
        nxt_edges    = hunting ? edges_ff : 3'h0;
        nxt_bitn     = bitn_ff;
        nxt_shift    = shift_ff;
        nxt_byte     = byte_ff;
        nxt_byte_pls = 1'b0;
        nxt_sync_pls = 1'b0;
        case (xstate_ff)
            X_IDLE: begin
                if (hunting) begin
                    if (edges_ff != 3'h0 && cnt_ff != 16'hFFFF) begin
                        nxt_cnt = cnt_ff + 16'h0001;
                    end
                    if (fall) begin
                        if (edges_ff == 3'h0) begin
                            // Counting this cycle too keeps the span a whole eight bits
                            nxt_cnt   = 16'h0001;
                            nxt_edges = 3'h1;
                        end else if (edges_ff == seq_pkg::SYNC_EDGES - 3'h1) begin
                            nxt_edges = 3'h0;
                            if ((cnt_ff >> seq_pkg::SYNC_SHIFT) >= seq_pkg::MIN_PERIOD) begin
                                nxt_period   = cnt_ff >> seq_pkg::SYNC_SHIFT;
                                nxt_sync_pls = 1'b1;
                            end
                        end else begin
                            nxt_edges = edges_ff + 3'h1;
                        end
                    end
                end else if (fall) begin
                    nxt_cnt    = period_ff >> 1;
                    nxt_xstate = X_START;
                end
            end
            X_START: begin
                if (cnt_ff <= 16'h0001) begin
                    nxt_cnt    = period_ff;
                    nxt_bitn   = 3'h0;
                    nxt_xstate = rx_s ? X_IDLE : X_DATA;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            X_DATA: begin
                if (cnt_ff <= 16'h0001) begin
                    nxt_shift = {rx_s, shift_ff[7:1]};
                    nxt_cnt   = period_ff;
                    nxt_bitn  = bitn_ff + 3'h1;
                    if (bitn_ff == 3'h7) begin
                        nxt_xstate = X_STOP;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            X_STOP: begin
                if (cnt_ff <= 16'h0001) begin
                    // Broken stop bit drops the byte, no parity to check
                    // Two cycles short, so sync hunt is armed for a back-to-back start bit
                    nxt_cnt    = (period_ff >> 1) - 16'h0002;
                    nxt_xstate = rx_s ? X_END : X_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            X_END: begin
                // Reports as the stop bit ends at the pin; the synchroniser lags by two
                if (cnt_ff <= 16'h0001) begin
                    nxt_byte_pls = 1'b1;
                    nxt_byte     = shift_ff;
                    nxt_xstate   = X_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            default: nxt_xstate = X_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (core_rst) begin
            xstate_ff   <= X_IDLE;
            cnt_ff      <= 16'h0000;
            period_ff   <= seq_pkg::RESET_PERIOD;
            edges_ff    <= 3'h0;
            bitn_ff     <= 3'h0;
            shift_ff    <= 8'h00;
            byte_ff     <= 8'h00;
            rx_prev_ff  <= 1'b1;
            byte_pls_ff <= 1'b0;
            sync_pls_ff <= 1'b0;
        end else begin
            xstate_ff   <= nxt_xstate;
            cnt_ff      <= nxt_cnt;
            period_ff   <= nxt_period;
            edges_ff    <= nxt_edges;
            bitn_ff     <= nxt_bitn;
            shift_ff    <= nxt_shift;
            byte_ff     <= nxt_byte;
            rx_prev_ff  <= rx_s;
            byte_pls_ff <= nxt_byte_pls;
            sync_pls_ff <= nxt_sync_pls;
        end
    end

    // Command decode, configuration and conversion control
    logic [7:0]  cfg_ff [0:4];
    logic [7:0]  nxt_cfg [0:4];
    logic [2:0]  waddr_ff, nxt_waddr, addr;
    logic [23:0] result_ff, nxt_result, ld_word;
    logic [1:0]  ld_len;
    logic        run_ff, nxt_run, single_ff, nxt_single, sleep_ff, nxt_sleep;
    logic        ready_n_ff, nxt_ready_n;
    logic [7:0]  rd_val;

    always_comb begin
        addr        = byte_ff[seq_pkg::ADDR_MSB:seq_pkg::ADDR_LSB];
        nxt_pstate  = pstate_ff;
        nxt_cfg     = cfg_ff;
        nxt_waddr   = waddr_ff;
        nxt_result  = result_ff;
        nxt_run     = run_ff;
        nxt_single  = single_ff;
        nxt_sleep   = sleep_ff;
        nxt_ready_n = ready_n_ff;
        nxt_soft_rst = 1'b0;
        ld_len      = 2'h0;
        ld_word     = 24'h000000;
        rd_val      = cfg_ff[addr];
        if (addr == 3'(seq_pkg::REG_PINS)) begin
            // Input pins read back their live level
            rd_val[2:0] = (cfg_ff[addr][6:4] & cfg_ff[addr][2:0]) | (~cfg_ff[addr][6:4] & pin_s);
        end
        case (pstate_ff)
            P_SYNC: begin
                if (sync_pls_ff) begin
                    nxt_pstate = P_CMD;
                end
            end
            P_CMD: begin
                if (byte_pls_ff) begin
                    nxt_pstate = P_SYNC;
                    if (byte_ff == seq_pkg::CMD_RESET) begin
                        nxt_soft_rst = 1'b1;
                    end else if (byte_ff == seq_pkg::CMD_START) begin
                        nxt_run    = 1'b1;
                        nxt_single = !cfg_ff[seq_pkg::REG_MODE][seq_pkg::CONT_BIT];
                        nxt_sleep  = 1'b0;
                    end else if (byte_ff == seq_pkg::CMD_SLEEP) begin
                        nxt_run   = 1'b0;
                        nxt_sleep = 1'b1;
                    end else if (byte_ff == seq_pkg::CMD_READ_DATA) begin
                        ld_len      = 2'(seq_pkg::RESULT_BYTES);
                        ld_word     = result_ff;
                        nxt_ready_n = 1'b1;
                    end else if (byte_ff[7:4] == seq_pkg::REG_WRITE_HI
                                 && addr < 3'(seq_pkg::REG_COUNT)) begin
                        nxt_waddr  = addr;
                        nxt_pstate = P_WDATA;
                    end else if (byte_ff[7:4] == seq_pkg::REG_READ_HI
                                 && addr < 3'(seq_pkg::REG_COUNT)) begin
                        ld_len  = 2'h1;
                        ld_word = {rd_val, 16'h0000};
                    end
                end
            end
            P_WDATA: begin
                if (byte_pls_ff) begin
                    nxt_cfg[waddr_ff] = byte_ff;
                    nxt_pstate        = P_SYNC;
                end
            end
            default: nxt_pstate = P_SYNC;
        endcase
        // New result wins over a same-cycle read that clears the flag
        if (CONV_DONE && run_ff) begin
            nxt_result  = CONV_DATA;
            nxt_ready_n = 1'b0;
            if (single_ff) begin
                nxt_run = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (core_rst) begin
            pstate_ff   <= P_SYNC;
            for (int i = 0; i < seq_pkg::REG_COUNT; i++) begin
                cfg_ff[i] <= seq_pkg::REG_RESET;
            end
            waddr_ff    <= 3'h0;
            result_ff   <= 24'h000000;
            run_ff      <= 1'b0;
            single_ff   <= 1'b0;
            sleep_ff    <= 1'b0;
            ready_n_ff  <= 1'b1;
            soft_rst_ff <= 1'b0;
        end else begin
            pstate_ff   <= nxt_pstate;
            cfg_ff      <= nxt_cfg;
            waddr_ff    <= nxt_waddr;
            result_ff   <= nxt_result;
            run_ff      <= nxt_run;
            single_ff   <= nxt_single;
            sleep_ff    <= nxt_sleep;
            ready_n_ff  <= nxt_ready_n;
            soft_rst_ff <= nxt_soft_rst;
        end
    end

    // Reply path: byte generator, buffer, serializer
    logic [1:0]  left_ff, nxt_left;
    logic [23:0] word_ff, nxt_word;
    tx_state_t   tstate_ff, nxt_tstate;
    logic [9:0]  frame_ff, nxt_frame;
    logic [15:0] tcnt_ff, nxt_tcnt;
    logic [3:0]  tbits_ff, nxt_tbits;
    logic        tx_ff, nxt_tx, fifo_in_ready, fifo_out_valid, push;
    logic [7:0]  fifo_out_data;

    byte_fifo2 #(.W(seq_pkg::BYTE_W)) reply_buf (
        .clk       (CLK_SYS),
        .rst       (core_rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (word_ff[23:16]),
        .out_valid (fifo_out_valid),
        .out_ready (tstate_ff == T_IDLE),
        .out_data  (fifo_out_data)
    );

    always_comb begin
        push       = (left_ff != 2'h0);
        nxt_left   = left_ff;
        nxt_word   = word_ff;
        nxt_tstate = tstate_ff;
        nxt_frame  = frame_ff;
        nxt_tcnt   = tcnt_ff;
        nxt_tbits  = tbits_ff;
        nxt_tx     = tx_ff;
        // A full buffer holds the generator, so no reply byte is lost
        if (push && fifo_in_ready) begin
            nxt_left = left_ff - 2'h1;
            nxt_word = {word_ff[15:0], 8'h00};
        end
        if (ld_len != 2'h0) begin
            nxt_left = ld_len;
            nxt_word = ld_word;
        end
        case (tstate_ff)
            T_IDLE: begin
                nxt_tx = 1'b1;
                if (fifo_out_valid) begin
                    nxt_frame  = {1'b1, fifo_out_data, 1'b0};
                    nxt_tx     = 1'b0;
                    nxt_tcnt   = period_ff;
                    nxt_tbits  = seq_pkg::FRAME_BITS;
                    nxt_tstate = T_SHIFT;
                end
            end
            T_SHIFT: begin
                if (tcnt_ff <= 16'h0001) begin
                    nxt_tcnt = period_ff;
                    if (tbits_ff == 4'h0) begin
                        nxt_tstate = T_IDLE;
                    end else begin
                        nxt_frame = {1'b1, frame_ff[9:1]};
                        nxt_tx    = frame_ff[1];
                        nxt_tbits = tbits_ff - 4'h1;
                    end
                end else begin
                    nxt_tcnt = tcnt_ff - 16'h0001;
                end
            end
            default: nxt_tstate = T_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (core_rst) begin
            left_ff   <= 2'h0;
            word_ff   <= 24'h000000;
            tstate_ff <= T_IDLE;
            frame_ff  <= 10'h3FF;
            tcnt_ff   <= 16'h0000;
            tbits_ff  <= 4'h0;
            tx_ff     <= 1'b1;
        end else begin
            left_ff   <= nxt_left;
            word_ff   <= nxt_word;
            tstate_ff <= nxt_tstate;
            frame_ff  <= nxt_frame;
            tcnt_ff   <= nxt_tcnt;
            tbits_ff  <= nxt_tbits;
            tx_ff     <= nxt_tx;
        end
    end

    // Registered outputs
    logic [7:0] r0, r4;
    logic [2:0] pin_out, pin_oe_n;

    always_comb begin
        r0       = cfg_ff[seq_pkg::REG_INPUT];
        r4       = cfg_ff[seq_pkg::REG_PINS];
        pin_oe_n = ~r4[6:4];
        pin_out  = r4[2:0];
        if (r4[seq_pkg::READY_SEL_BIT]) begin
            pin_out[2] = ready_n_ff;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (core_rst) begin
            TX                       <= 1'b1;
            CONV_RUN                 <= 1'b0;
            LOW_POWER                <= 1'b0;
            INPUT_SELECT             <= 4'h0;
            GAIN_CODE                <= 3'h0;
            AMP_BYPASS               <= 1'b0;
            MID_SHORT                <= 1'b0;
            {SHARED_IO_READY_PIN_OUT, GENERAL_PIN_1_OUT, GENERAL_PIN_0_OUT} <= 3'h0;
            {SHARED_IO_READY_PIN_OE_N, GENERAL_PIN_1_OE_N, GENERAL_PIN_0_OE_N} <= 3'h7;
        end else begin
            TX           <= tx_ff;
            CONV_RUN     <= run_ff;
            LOW_POWER    <= sleep_ff;
            INPUT_SELECT <= r0[seq_pkg::SEL_MSB:seq_pkg::SEL_LSB];
            GAIN_CODE    <= r0[seq_pkg::GAIN_MSB:seq_pkg::GAIN_LSB];
            // Higher gains force the amplifier back in
            AMP_BYPASS   <= r0[seq_pkg::BYPASS_BIT]
                            && r0[seq_pkg::GAIN_MSB:seq_pkg::GAIN_LSB] <= seq_pkg::GAIN_MAX_BYP;
            MID_SHORT    <= r0[seq_pkg::SEL_MSB:seq_pkg::SEL_LSB] == seq_pkg::SEL_MID_SHORT;
            {SHARED_IO_READY_PIN_OUT, GENERAL_PIN_1_OUT, GENERAL_PIN_0_OUT} <= pin_out;
            {SHARED_IO_READY_PIN_OE_N, GENERAL_PIN_1_OE_N, GENERAL_PIN_0_OE_N} <= pin_oe_n;
        end
    end
endmodule

// [verification/host_uart_model.sv]
// Host serial port model: sends framed commands, captures reply bytes
module host_uart_model (
    input wire logic clk,
    output logic     rx_line,
    input wire logic tx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rx_line = 1'b1;
    task automatic send_byte(input logic [7:0] b, input int p);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (p) @(posedge clk);
        end
    endtask
    // Host picks the rate freely; the sync byte carries it
    task automatic command(input logic [7:0] c, input int p);
        send_byte(seq_pkg::SYNC_BYTE, p);
        send_byte(c, p);
    endtask
    // Samples on the falling edge so registered TX has settled
    task automatic recv_byte(output logic [7:0] b, output logic ok, input int p);
        int n;
        ok = 1'b0;
        b = 8'h00;
        for (n = 0; n < 4000 && tx_line; n++) @(negedge clk);
        if (!tx_line) begin
            repeat (p / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (p) @(negedge clk);
                b[i] = tx_line;
            end
            repeat (p) @(negedge clk);
            ok = tx_line;
        end
    endtask
endmodule

// [verification/seq_monitor.sv]
// Port-level assertions for the serial command sequencer
module seq_monitor (
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       RESET_N_PIN,
    input wire logic       RX,
    input wire logic       TX,
    input wire logic       CONV_RUN,
    input wire logic       LOW_POWER,
    input wire logic [3:0] INPUT_SELECT,
    input wire logic [2:0] GAIN_CODE,
    input wire logic       AMP_BYPASS,
    input wire logic       MID_SHORT,
    input wire logic       GENERAL_PIN_0_OE_N,
    input wire logic       GENERAL_PIN_1_OE_N,
    input wire logic       SHARED_IO_READY_PIN_OE_N
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic all_in;
    assign all_in = GENERAL_PIN_0_OE_N & GENERAL_PIN_1_OE_N & SHARED_IO_READY_PIN_OE_N;
    // Five cycles covers the two-flop synchroniser plus the core flop
    sequence pin_held_low;
        !RESET_N_PIN [*5];
    endsequence
    sequence start_bit;
        $fell(TX) ##0 !TX [*4];
    endsequence
    a_pin_reset: assert property (pin_held_low |-> all_in && TX && !CONV_RUN)
        else $error("reset pin low did not reset core");
    a_tx_start: assert property ($fell(TX) |-> start_bit)
        else $error("transmit start bit shorter than minimum period");
    a_reply_wait: assert property (!RX |-> TX)
        else $error("transmit active while command still arriving");
    a_sleep_halts: assert property (LOW_POWER ##1 LOW_POWER |-> !CONV_RUN)
        else $error("converter running in low power");
    a_run_awake: assert property (CONV_RUN ##1 CONV_RUN |-> !LOW_POWER)
        else $error("low power set while running");
    a_short_code: assert property (MID_SHORT == (INPUT_SELECT == seq_pkg::SEL_MID_SHORT))
        else $error("mid short flag disagrees with input select");
    a_bypass_gain: assert property (AMP_BYPASS |-> GAIN_CODE <= seq_pkg::GAIN_MAX_BYP)
        else $error("bypass with gain above four");
    a_pins_default: assert property ($fell(RST) |-> all_in)
        else $error("pin driven after reset");
endmodule
bind uart_adc_command_sequencer seq_monitor u_mon (.CLK_SYS, .RST, .RESET_N_PIN, .RX, .TX,
    .CONV_RUN, .LOW_POWER, .INPUT_SELECT, .GAIN_CODE, .AMP_BYPASS, .MID_SHORT,
    .GENERAL_PIN_0_OE_N, .GENERAL_PIN_1_OE_N, .SHARED_IO_READY_PIN_OE_N);

// [verification/uart_adc_command_sequencer_bench.sv]
// Self-checking bench for the serial command sequencer
module uart_adc_command_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P = 8;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        reset_n_pin = 1'b1;
    logic        conv_done = 1'b0;
    logic [23:0] conv_data = 24'h000000;
    logic        rx, tx, conv_run, low_power, amp_bypass, mid_short;
    logic [3:0]  input_select;
    logic [2:0]  gain_code, pin_out, pin_oe_n, pin_in;
    int          failures = 0;
    int          n_tests = 0;
    always #50 clk_sys = ~clk_sys;
    // Released pins float high through the board pull-up
    assign pin_in = pin_out | pin_oe_n;
    host_uart_model host (.clk(clk_sys), .rx_line(rx), .tx_line(tx));
    uart_adc_command_sequencer dut (.CLK_SYS(clk_sys), .RST(rst), .RESET_N_PIN(reset_n_pin),
        .RX(rx), .TX(tx), .CONV_DONE(conv_done), .CONV_DATA(conv_data), .CONV_RUN(conv_run),
        .LOW_POWER(low_power), .INPUT_SELECT(input_select), .GAIN_CODE(gain_code),
        .AMP_BYPASS(amp_bypass), .MID_SHORT(mid_short),
        .GENERAL_PIN_0_IN(pin_in[0]), .GENERAL_PIN_0_OUT(pin_out[0]),
        .GENERAL_PIN_0_OE_N(pin_oe_n[0]), .GENERAL_PIN_1_IN(pin_in[1]),
        .GENERAL_PIN_1_OUT(pin_out[1]), .GENERAL_PIN_1_OE_N(pin_oe_n[1]),
        .SHARED_IO_READY_PIN_IN(pin_in[2]), .SHARED_IO_READY_PIN_OUT(pin_out[2]),
        .SHARED_IO_READY_PIN_OE_N(pin_oe_n[2]));
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("Checks %0d, failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic read_check(input string name, input logic [7:0] exp, input int p);
        logic [7:0] b;
        logic       ok;
        host.recv_byte(b, ok, p);
        if (!ok) begin
            failures++;
            results();
        end
        check(name, 24'(b), 24'(exp));
    endtask
    task automatic write_reg(input logic [7:0] c, input logic [7:0] d);
        host.command(c, P);
        host.send_byte(d, P);
        repeat (P) @(posedge clk_sys);
    endtask
    task automatic t_defaults();
        check("pin enables", 24'(pin_oe_n), 24'h7);
        check("idle tx", 24'(tx), 24'h1);
        check("run", 24'({conv_run, low_power, input_select}), 24'h0);
    endtask
    task automatic t_write_read();
        write_reg(8'h40, 8'hE3);
        check("select", 24'(input_select), 24'hE);
        check("short", 24'(mid_short), 24'h1);
        check("bypass low gain", 24'(amp_bypass), 24'h1);
        host.command(8'h20, P);
        read_check("reg0 read", 8'hE3, P);
        write_reg(8'h40, 8'h07);
        check("bypass high gain", 24'({gain_code, amp_bypass}), 24'h6);
    endtask
    task automatic t_stream();
        write_reg(8'h42, 8'h08);
        write_reg(8'h48, 8'h48);
        // Released pins read back high through the pull-up
        host.command(8'h28, P);
        read_check("reg4 read", 8'h4B, P);
        host.command(seq_pkg::CMD_START, P);
        repeat (P) @(posedge clk_sys);
        check("running", 24'(conv_run), 24'h1);
        check("ready idle", 24'({pin_oe_n[2], pin_out[2]}), 24'h1);
        conv_done <= 1'b1;
        conv_data <= 24'hA5C31E;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("ready low", 24'(pin_out[2]), 24'h0);
        host.command(seq_pkg::CMD_READ_DATA, 12);
        read_check("result hi", 8'hA5, 12);
        read_check("result mid", 8'hC3, 12);
        read_check("result lo", 8'h1E, 12);
        check("ready cleared", 24'(pin_out[2]), 24'h1);
    endtask
    task automatic t_pin_reset();
        reset_n_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("pin reset", 24'({conv_run, pin_oe_n, input_select}), 24'h70);
        reset_n_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic t_sleep_reset();
        write_reg(8'h40, 8'hE3);
        host.command(seq_pkg::CMD_SLEEP, P);
        repeat (P) @(posedge clk_sys);
        check("sleep", 24'({low_power, conv_run}), 24'h2);
        host.command(seq_pkg::CMD_RESET, P);
        repeat (50) @(posedge clk_sys);
        check("soft reset", 24'({low_power, input_select}), 24'h0);
        // Mode register back at default: start gives one conversion only
        host.command(seq_pkg::CMD_START, P);
        repeat (P) @(posedge clk_sys);
        check("single run", 24'(conv_run), 24'h1);
        conv_done <= 1'b1;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("single stop", 24'(conv_run), 24'h0);
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (500) @(posedge clk_sys);
        t_defaults();
        t_write_read();
        t_stream();
        t_pin_reset();
        t_sleep_reset();
        results();
    end
endmodule
